/* rtl/ilog_slave.sv */
`timescale 1ns/100ps
// Overview of operation
// - Bus writes into the event-log area are dropped; only internal logging writes it.
// - Mission start is refused unless the memory-cleared flag is one.
// - Any bus data write, except a status write with mission-active set, stops logging, clearing mission-active and mission-enable.
// - Slave only: SDA and SCL are inputs; SDA is driven low open-drain.
// - SDA is sampled on SCL rise and changed only while SCL is low.
// - SDA falling while SCL is high is a START.
// - SDA rising while SCL is high is a STOP and ends the transfer.
// - Eight data bits then one acknowledge bit, any number of bytes.
// - Works at standard and fast mode clock rates.
// - Acknowledge holds SDA low over the whole ninth clock high phase.
// - On master not-acknowledge the slave releases SDA and stops sending.
// - Repeated START begins a fresh address phase.
// - Write: address byte with direction 0, then a byte loading the pointer.
// - Address, pointer and every data byte are acknowledged during writes.
// - Read: acknowledge address, then send bytes from the pointer location.
// - Writing zero to mission-active stops the mission and clears mission-enable.
// - Memory-cleared flag drops when a mission starts.
module ilog_slave
    import ilog_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic log_wr_en,
    input wire logic [7:0] log_addr,
    input wire logic [7:0] log_wdata,
    input wire logic event_start,
    input wire logic mem_clear_done,
    output logic mission_active_flag,
    output logic mission_enable_bit,
    output logic memory_cleared_flag,
    output logic busy
);
    ilog_mem_if mem_bus ();

    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    ilog_state_e state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rw_reg, rw_next;
    logic ack_reg, ack_next;
    logic drive_reg, drive_next;
    logic nack_reg, nack_next;
    logic wr_en_reg, wr_en_next;
    logic [7:0] wdata_reg, wdata_next;
    logic load_reg, load_next;
    logic active_reg, active_next;
    logic enable_reg, enable_next;
    logic cleared_reg, cleared_next;
    logic busy_reg, busy_next;
    logic [7:0] rd_byte;

    function automatic logic [7:0] ilog_ptr_inc(input logic [7:0] p);
        return p + 8'h01;
    endfunction

    ilog_sync u_sync_scl (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(scl_in),
        .sync_out(scl_s)
    );

    ilog_sync u_sync_sda (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(sda_in),
        .sync_out(sda_s)
    );

    ilog_regfile u_regfile (
        .clk(clk),
        .rst_n(rst_n),
        .bus(mem_bus),
        .log_wr_en(log_wr_en),
        .log_addr(log_addr),
        .log_wdata(log_wdata)
    );

    assign mem_bus.wr_en = wr_en_reg;
    assign mem_bus.addr = ptr_reg;
    assign mem_bus.wdata = wdata_reg;

    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    always_comb begin
        rd_byte = mem_bus.rdata;
        if (ptr_reg == ILOG_STATUS_ADDR) begin
            rd_byte = ILOG_BYTE_RESET;
            rd_byte[ILOG_STAT_MEMCLR_POS] = cleared_reg;
            rd_byte[ILOG_STAT_ACTIVE_POS] = active_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        ack_next = ack_reg;
        drive_next = drive_reg;
        nack_next = nack_reg;
        wr_en_next = 1'b0;
        wdata_next = wdata_reg;
        load_next = 1'b0;
        active_next = active_reg;
        enable_next = enable_reg;
        cleared_next = cleared_reg;
        busy_next = busy_reg;

        if (mem_clear_done) begin
            cleared_next = 1'b1;
        end
        if (event_start && enable_reg && cleared_reg) begin
            active_next = 1'b1;
            cleared_next = 1'b0;
        end

        if (start_det) begin
            state_next = ILOG_ADDR;
            bit_next = 4'h0;
            ack_next = 1'b0;
            drive_next = 1'b0;
            busy_next = 1'b1;
        end else if (stop_det) begin
            state_next = ILOG_IDLE;
            drive_next = 1'b0;
            ack_next = 1'b0;
            busy_next = 1'b0;
        end else if (state_reg != ILOG_IDLE && state_reg != ILOG_IGNORE) begin
            if (scl_rise) begin
                if (state_reg == ILOG_RDATA) begin
                    // Transmit shifter stays put; only the master's answer is taken
                    if (bit_reg == ILOG_BIT_ACK) begin
                        nack_next = sda_s;
                    end
                end else if (bit_reg <= ILOG_BIT_LAST) begin
                    shift_next = {shift_reg[6:0], sda_s};
                end
                bit_next = bit_reg + 4'h1;
            end else if (scl_fall) begin
                if (bit_reg == ILOG_BIT_LAST + 4'h1) begin
                    // Falling edge after the eighth bit: decide acknowledge
                    drive_next = 1'b0;
                    unique case (state_reg)
                        ILOG_ADDR: begin
                            if (shift_reg[7:1] == ILOG_SLAVE_ADDR) begin
                                ack_next = 1'b1;
                                rw_next = shift_reg[0];
                            end else begin
                                state_next = ILOG_IGNORE;
                                busy_next = 1'b0;
                            end
                        end
                        ILOG_REG: begin
                            ack_next = 1'b1;
                            ptr_next = shift_reg;
                        end
                        ILOG_WDATA: begin
                            ack_next = 1'b1;
                            wdata_next = shift_reg;
                            if (ptr_reg == ILOG_STATUS_ADDR) begin
                                if (!shift_reg[ILOG_STAT_ACTIVE_POS]) begin
                                    active_next = 1'b0;
                                    enable_next = 1'b0;
                                end else if (cleared_reg) begin
                                    active_next = 1'b1;
                                    enable_next = 1'b1;
                                    cleared_next = 1'b0;
                                end
                            end else begin
                                // Log area is read only from the bus
                                wr_en_next = (ptr_reg < ILOG_LOG_BASE);
                                active_next = 1'b0;
                                enable_next = 1'b0;
                            end
                        end
                        ILOG_RDATA: begin
                            // Advance now so the next byte is fetched during the ack clock
                            ptr_next = ilog_ptr_inc(ptr_reg);
                        end
                        default: begin
                            ack_next = 1'b0;
                        end
                    endcase
                end else if (bit_reg == ILOG_BIT_ACK + 4'h1) begin
                    // End of acknowledge clock
                    ack_next = 1'b0;
                    bit_next = 4'h0;
                    drive_next = 1'b0;
                    unique case (state_reg)
                        ILOG_ADDR: begin
                            if (rw_reg) begin
                                state_next = ILOG_RDATA;
                                drive_next = !rd_byte[7];
                                shift_next = {rd_byte[6:0], 1'b0};
                                load_next = 1'b1;
                            end else begin
                                state_next = ILOG_REG;
                            end
                        end
                        ILOG_REG: begin
                            state_next = ILOG_WDATA;
                        end
                        ILOG_WDATA: begin
                            ptr_next = ilog_ptr_inc(ptr_reg);
                        end
                        ILOG_RDATA: begin
                            if (nack_reg) begin
                                state_next = ILOG_IGNORE;
                            end else begin
                                drive_next = !rd_byte[7];
                                shift_next = {rd_byte[6:0], 1'b0};
                            end
                        end
                        default: begin
                            state_next = ILOG_IGNORE;
                        end
                    endcase
                end else if (state_reg == ILOG_RDATA && bit_reg < ILOG_BIT_LAST + 4'h1) begin
                    drive_next = !shift_reg[7];
                    shift_next = {shift_reg[6:0], 1'b0};
                end
            end
        end

        // First byte after the address acknowledge is loaded once more
        if (load_reg && state_reg == ILOG_RDATA && bit_reg == 4'h0) begin
            drive_next = !rd_byte[7];
            shift_next = {rd_byte[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            state_reg <= ILOG_IDLE;
            bit_reg <= 4'h0;
            shift_reg <= ILOG_BYTE_RESET;
            ptr_reg <= ILOG_PTR_RESET;
            rw_reg <= 1'b0;
            ack_reg <= 1'b0;
            drive_reg <= 1'b0;
            nack_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wdata_reg <= ILOG_BYTE_RESET;
            load_reg <= 1'b0;
            active_reg <= 1'b0;
            enable_reg <= 1'b0;
            cleared_reg <= 1'b0;
            busy_reg <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            state_reg <= state_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            ack_reg <= ack_next;
            drive_reg <= drive_next;
            nack_reg <= nack_next;
            wr_en_reg <= wr_en_next;
            wdata_reg <= wdata_next;
            load_reg <= load_next;
            active_reg <= active_next;
            enable_reg <= enable_next;
            cleared_reg <= cleared_next;
            busy_reg <= busy_next;
            sda_oe_n <= !(ack_next || drive_next);
        end
    end

    assign sda_out = 1'b0;
    assign mission_active_flag = active_reg;
    assign mission_enable_bit = enable_reg;
    assign memory_cleared_flag = cleared_reg;
    assign busy = busy_reg;
endmodule

/* include/ilog_pkg.sv */
package ilog_pkg;
    // Bus address of this slave; value is arbitrary
    localparam logic [6:0] ILOG_SLAVE_ADDR = 7'h2C;
    localparam int ILOG_PTR_W = 8;
    localparam int ILOG_MEM_DEPTH = 256;
    // Pointer regions
    localparam logic [7:0] ILOG_LOG_BASE = 8'h40;
    localparam logic [7:0] ILOG_STATUS_ADDR = 8'h0F;
    localparam int ILOG_STAT_MEMCLR_POS = 6;
    localparam int ILOG_STAT_ACTIVE_POS = 5;
    localparam logic [7:0] ILOG_PTR_RESET = 8'h00;
    localparam logic [7:0] ILOG_BYTE_RESET = 8'h00;
    localparam logic [3:0] ILOG_BIT_LAST = 4'h7;
    localparam logic [3:0] ILOG_BIT_ACK = 4'h8;
    // Slowest legal link is 100 kHz, fastest 400 kHz; a 2-flop synchroniser at
    // 25 MHz leaves over 20 samples per fast-mode half period.
    localparam int ILOG_CLK_MHZ = 25;
    localparam int ILOG_SCL_FAST_KHZ = 400;
    localparam int ILOG_SCL_HALF_CYC = (ILOG_CLK_MHZ * 1000) / (ILOG_SCL_FAST_KHZ * 2);
    typedef enum logic [2:0] {
        ILOG_IDLE,
        ILOG_ADDR,
        ILOG_REG,
        ILOG_WDATA,
        ILOG_RDATA,
        ILOG_IGNORE
    } ilog_state_e;
endpackage

/* include/ilog_mem_if.sv */
`timescale 1ns/100ps
interface ilog_mem_if;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport master (output wr_en, output addr, output wdata, input rdata);
    modport slave (input wr_en, input addr, input wdata, output rdata);
endinterface

/* rtl/ilog_sync.sv */
`timescale 1ns/100ps
module ilog_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    logic sync_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end
    assign sync_out = sync_reg;
endmodule

/* rtl/ilog_regfile.sv */
`timescale 1ns/100ps
module ilog_regfile
    import ilog_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    ilog_mem_if.slave bus,
    input wire logic log_wr_en,
    input wire logic [7:0] log_addr,
    input wire logic [7:0] log_wdata
);
    logic [7:0] mem [ILOG_MEM_DEPTH];
    logic [7:0] rdata_reg;
    always_ff @(posedge clk) begin
        if (log_wr_en) begin
            mem[log_addr] <= log_wdata;
        end else if (bus.wr_en && bus.addr < ILOG_LOG_BASE) begin
            mem[bus.addr] <= bus.wdata;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= ILOG_BYTE_RESET;
        end else begin
            rdata_reg <= mem[bus.addr];
        end
    end
    assign bus.rdata = rdata_reg;
endmodule

/* tb/ilog_chk.sv */
`timescale 1ns/100ps
module ilog_chk
    import ilog_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic log_wr_en,
    input wire logic [7:0] log_addr,
    input wire logic [7:0] log_wdata,
    input wire logic event_start,
    input wire logic mem_clear_done,
    input wire logic mission_active_flag,
    input wire logic mission_enable_bit,
    input wire logic memory_cleared_flag,
    input wire logic busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    open_drain_a: assert property (sda_out == 1'b0)
        else $error("data pin output not held low");
    sda_stable_a: assert property ($changed(sda_oe_n) |-> !scl_in || !$past(scl_in))
        else $error("data drive changed while clock high");
    ack_hold_a: assert property ($rose(scl_in) && !sda_oe_n |=> (!sda_oe_n || !scl_in) [*3])
        else $error("low drive dropped during clock high");
    start_guard_a: assert property ($rose(mission_active_flag) |-> $past(memory_cleared_flag))
        else $error("mission began without cleared memory");
    clr_drop_a: assert property ($rose(mission_active_flag) |-> ##[0:2] !memory_cleared_flag)
        else $error("cleared flag kept after mission start");
    stop_clear_a: assert property ($fell(mission_active_flag) |-> ##[0:2] !mission_enable_bit)
        else $error("enable bit kept after mission stop");
    idle_quiet_a: assert property (!busy && !$past(busy) |-> sda_oe_n)
        else $error("data driven while not addressed");
    stop_end_a: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:8] !busy)
        else $error("busy kept after stop condition");
endmodule

bind ilog_slave ilog_chk chk_u (.clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .log_wr_en(log_wr_en), .log_addr(log_addr),
    .log_wdata(log_wdata), .event_start(event_start), .mem_clear_done(mem_clear_done),
    .mission_active_flag(mission_active_flag), .mission_enable_bit(mission_enable_bit),
    .memory_cleared_flag(memory_cleared_flag), .busy(busy));

/* tb/ilog_master.sv */
`timescale 1ns/100ps
module ilog_master (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // SDA moves only in the low phase; the line is read late in the high phase
    task automatic bit_io(input logic b, output logic r);
        @(posedge clk) scl_o <= 1'b0;
        @(posedge clk) sda_o <= b;
        tick(2);
        @(posedge clk) scl_o <= 1'b1;
        tick(3);
        r = sda_in;
    endtask
    task automatic start();
        logic r;
        bit_io(1'b1, r);
        @(posedge clk) sda_o <= 1'b0;
        tick(3);
    endtask
    task automatic stop();
        logic r;
        bit_io(1'b0, r);
        @(posedge clk) sda_o <= 1'b1;
        tick(8);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule

/* tb/i2c_slave_log_access_tb.sv */
`timescale 1ns/100ps
module i2c_slave_log_access_tb
    import ilog_pkg::*;
();
    `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
    logic clk, rst_n, log_wr_en, event_start, mem_clear_done, ack;
    logic [7:0] log_addr, log_wdata, p, v, d0, d1;
    logic scl_m, sda_m, sda_out, sda_oe_n;
    logic mission_active_flag, mission_enable_bit, memory_cleared_flag, busy;
    logic [7:0] ref_mem [256];
    int fail_count = 0;
    int num_checks = 0;
    integer seed = 32'h643f;
    wire sda_w = sda_m & (sda_oe_n | sda_out);

    ilog_slave dut_u (.clk(clk), .rst_n(rst_n), .scl_in(scl_m), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .log_wr_en(log_wr_en), .log_addr(log_addr),
        .log_wdata(log_wdata), .event_start(event_start), .mem_clear_done(mem_clear_done),
        .mission_active_flag(mission_active_flag), .mission_enable_bit(mission_enable_bit),
        .memory_cleared_flag(memory_cleared_flag), .busy(busy));
    ilog_master m_u (.clk(clk), .sda_in(sda_w), .scl_o(scl_m), .sda_o(sda_m));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic lands(input logic [7:0] q);
        return q < ILOG_LOG_BASE && q != ILOG_STATUS_ADDR;
    endfunction
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] q, input logic [7:0] a, b, input int n);
        m_u.start();
        m_u.send({ILOG_SLAVE_ADDR, 1'b0}, ack);
        `CHK(ack, 1'b1)
        m_u.send(q, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            m_u.send(i == 0 ? a : b, ack);
            `CHK(ack, 1'b1)
            if (lands(q)) ref_mem[q] = i == 0 ? a : b;
            q++;
        end
        m_u.stop();
    endtask
    task automatic rd(input logic [7:0] q, output logic [7:0] a, b);
        m_u.start();
        m_u.send({ILOG_SLAVE_ADDR, 1'b0}, ack);
        m_u.send(q, ack);
        m_u.start();
        m_u.send({ILOG_SLAVE_ADDR, 1'b1}, ack);
        `CHK(ack, 1'b1)
        m_u.recv(1'b0, a);
        m_u.recv(1'b1, b);
        `CHK(sda_oe_n, 1'b1)
        m_u.stop();
        `CHK(busy, 1'b0)
    endtask
    task automatic pulse_start();
        @(posedge clk) event_start <= 1'b1;
        @(posedge clk) event_start <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(mission_active_flag, 1'b0)
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        close_out();
    end
    initial begin
        rst_n = 1'b0;
        log_wr_en = 1'b0;
        log_addr = 8'h00;
        log_wdata = 8'h00;
        event_start = 1'b0;
        mem_clear_done = 1'b0;
        repeat (12) @(posedge clk);
        `CHK({mission_active_flag, mission_enable_bit, memory_cleared_flag}, 3'h0)
        `CHK(sda_oe_n, 1'b1)
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        v = 8'($random(seed));
        log_addr <= ILOG_LOG_BASE;
        log_wdata <= v;
        log_wr_en <= 1'b1;
        @(posedge clk) log_wr_en <= 1'b0;
        ref_mem[ILOG_LOG_BASE] = v;
        // First pass runs off the top of the writable area into the log
        for (int k = 0; k < 6; k++) begin
            p = k == 0 ? 8'h3f : 8'h10 + (8'($random(seed)) & 8'h2e);
            v = 8'($random(seed));
            wr(p, v, ~v ^ 8'(k), 2);
            rd(p, d0, d1);
            `CHK(d0, ref_mem[p])
            `CHK(d1, ref_mem[8'(p + 8'h01)])
        end
        $display("test write_readback done");
        for (int k = 0; k < 2; k++) begin
            m_u.start();
            m_u.send({ILOG_SLAVE_ADDR ^ (7'($random(seed)) | 7'h01), 1'(k)}, ack);
            `CHK(ack, 1'b0)
            m_u.send(8'h10, ack);
            `CHK({ack, busy}, 2'h0)
            m_u.stop();
        end
        $display("test foreign_address done");
        pulse_start();
        wr(ILOG_STATUS_ADDR, 8'h20, 8'h00, 1);
        `CHK(mission_active_flag, 1'b0)
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) mem_clear_done <= 1'b1;
            @(posedge clk) mem_clear_done <= 1'b0;
            repeat (3) @(posedge clk);
            `CHK(memory_cleared_flag, 1'b1)
            wr(ILOG_STATUS_ADDR, 8'h20, 8'h00, 1);
            `CHK({mission_active_flag, mission_enable_bit, memory_cleared_flag}, 3'h6)
            rd(ILOG_STATUS_ADDR, d0, d1);
            `CHK({d0[ILOG_STAT_MEMCLR_POS], d0[ILOG_STAT_ACTIVE_POS]}, 2'h1)
            p = k == 0 ? 8'h20 : ILOG_STATUS_ADDR;
            wr(p, 8'h00, 8'h00, 1);
            `CHK({mission_active_flag, mission_enable_bit}, 2'h0)
        end
        pulse_start();
        $display("test mission_guard done");
        close_out();
    end
endmodule
